// >>> hw/mdt_regs.svh
/*
  Constants of the instruction decode and timing block: opcode field
  positions, instruction cycle length and reset values.
  Assumes it is included by its bare name from the package and modules.
*/
// Function
// [RQ1] Recognise 75 base instructions plus 8 extended stack-oriented instructions.
// [RQ2] One-word instruction is 16 bits: opcode plus operand fields.
// [RQ3] Exactly four instructions span two words, 32 bits in total.
// [RQ4] Second word has top four bits ones; alone it acts as no-op.
// [RQ5] One-word instruction: one cycle; two when test true or PC changes.
// [RQ6] Every two-word instruction takes two instruction cycles; a taken two-word branch here takes three.
// [RQ7] One instruction cycle spans four oscillator periods.
// [RQ8] Taken two-word branch occupies three instruction cycles.
// [RQ9] Byte instructions give file address, destination bit and access bit.
// [RQ10] Destination zero writes working register; one writes file register.
// [RQ11] Bit instructions give file address, bit number and access bit.
// [RQ12] Literal instructions give constant, optional pointer select, or nothing.
// [RQ13] Control instructions give address, call/return mode, table mode, or nothing.
// [RQ14] Access bit zero uses access bank; one uses bank select register.
// [RQ15] Call/return mode one uses shadow copies; zero leaves them alone.
// [RQ16] Table mode: no change, post-increment, post-decrement, pre-increment.
// [RQ17] File operand is 8-bit address or 2-bit indirect pointer designator.
// [RQ18] Word following a two-word first word is consumed as operand.
// [RQ19] Word fetched before an added cycle is discarded, no state change.
`ifndef MDT_REGS_SVH
`define MDT_REGS_SVH

// Instruction cycle length in oscillator periods
`define MDT_Q_PER_CYCLE 3'h4
// Second word marker in the top nibble
`define MDT_SECOND_MARK 4'hF
`define MDT_SECOND_POS 12
// Field positions
`define MDT_F_LSB 0
`define MDT_D_POS 9
`define MDT_A_POS 8
`define MDT_B_LSB 9
`define MDT_S_POS 0
`define MDT_PTR_LSB 4
// Reset values
`define MDT_IR_RESET 16'hF000
`define MDT_Q_RESET 2'h0

`endif

// >>> hw/mdt_pkg.sv
/*
  Types of the instruction decode and timing block.
  Assumes mdt_regs.svh is on the include path.
*/
package mdt_pkg;
  `include "mdt_regs.svh"

  // Instruction class
  typedef enum logic [2:0]
  {
    MDT_CL_BYTE = 3'h0,
    MDT_CL_BIT = 3'h1,
    MDT_CL_LIT = 3'h2,
    MDT_CL_CTRL = 3'h3,
    MDT_CL_EXT = 3'h4,
    MDT_CL_NOP = 3'h5
  } mdt_class_e;

  // Table pointer behaviour
  typedef enum logic [1:0]
  {
    MDT_TB_NONE = 2'h0,
    MDT_TB_POSTINC = 2'h1,
    MDT_TB_POSTDEC = 2'h2,
    MDT_TB_PREINC = 2'h3
  } mdt_tbl_e;

  // Sequencer state
  typedef enum logic [1:0]
  {
    MDT_ST_EXEC = 2'h0,
    MDT_ST_WORD2 = 2'h1,
    MDT_ST_FLUSH = 2'h2
  } mdt_state_e;
endpackage

// >>> hw/mdt_field_decode.sv
/*
  Combinational sorting of one 16-bit program word into class and operands.
  Assumes the word is stable in the last quarter of the instruction cycle, where it is sampled.
*/
`include "mdt_regs.svh"

module mdt_field_decode
  import mdt_pkg::*;
(
  // Program word
  input wire logic [15:0] word,
  // Decoded fields
  output mdt_pkg::mdt_class_e op_class,
  output logic two_word,
  output logic is_branch,
  output logic is_skip,
  output logic [7:0] file_addr,
  output logic dest_file,
  output logic use_bank,
  output logic [2:0] bit_num,
  output logic [7:0] literal,
  output logic [1:0] ptr_sel,
  output logic fast_mode,
  output logic [10:0] prog_addr,
  output mdt_pkg::mdt_tbl_e tbl_mode,
  output logic tbl_op
);
  import mdt_pkg::*;

  // Classify by opcode bits and pull out operand fields
  always_comb
  begin
    file_addr = word[`MDT_F_LSB +: 8]; // RQ17
    dest_file = word[`MDT_D_POS]; // RQ9
    use_bank = word[`MDT_A_POS]; // RQ14
    bit_num = word[`MDT_B_LSB +: 3]; // RQ11
    literal = word[7:0]; // RQ12
    ptr_sel = word[`MDT_PTR_LSB +: 2]; // RQ17
    fast_mode = word[`MDT_S_POS]; // RQ15
    prog_addr = word[10:0]; // RQ13
    tbl_mode = mdt_tbl_e'(word[1:0]); // RQ16
    tbl_op = (word[15:3] == 13'h0001); // RQ13
    two_word = 1'b0;
    is_branch = 1'b0;
    is_skip = 1'b0;
    op_class = MDT_CL_BYTE; // RQ2
    if (word[15:12] == `MDT_SECOND_MARK)
    begin
      op_class = MDT_CL_NOP; // RQ4
    end
    else if (word[15:12] >= 4'h7 && word[15:12] <= 4'hB)
    begin
      op_class = MDT_CL_BIT; // RQ11
      is_skip = (word[15:12] == 4'hA) || (word[15:12] == 4'hB);
    end
    else if (word[15:12] == 4'hC)
    begin
      op_class = MDT_CL_BYTE;
      two_word = 1'b1; // RQ3
    end
    else if (word[15:12] == 4'hD)
    begin
      op_class = MDT_CL_CTRL;
      is_branch = 1'b1;
    end
    else if (word[15:12] == 4'hE)
    begin
      op_class = MDT_CL_CTRL; // RQ13
      if (word[11:8] == 4'hC || word[11:8] == 4'hD || word[11:8] == 4'hF)
      begin
        two_word = 1'b1; // RQ3
        is_branch = 1'b1;
      end
      else if (word[11:8] == 4'hE)
      begin
        op_class = MDT_CL_LIT; // RQ12
        two_word = 1'b1; // RQ3
      end
      else if (word[11:8] == 4'h8 || word[11:8] == 4'hA)
      begin
        op_class = MDT_CL_EXT; // RQ1
      end
      else
      begin
        is_branch = 1'b1;
      end
    end
    else if (word[15:8] == 8'h0E || word[15:12] == 4'h0 && word[11:8] >= 4'h8)
    begin
      op_class = MDT_CL_LIT; // RQ12
    end
    else if (word[15:8] == 8'h00)
    begin
      op_class = MDT_CL_CTRL; // RQ13
      is_branch = (word[7:1] == 7'h08) || (word[7:1] == 7'h09);
    end
    else if (word[15:12] == 4'h6 && (word[11:9] == 3'h1 || word[11:9] == 3'h2))
    begin
      is_skip = 1'b1;
    end
  end
endmodule

// >>> hw/mdt_decode_timing.sv
/*
  Instruction decode and cycle sequencer: splits each instruction cycle into
  four oscillator periods, latches the fetched word and issues decoded
  controls, extra no-op cycles and two-word operand handling.
  The word on fetch_word is taken only at the edge that closes the fourth
  quarter; in the other quarters the fetch path may still be settling.
  Decoded fields hold from one dispatch to the next, so an added cycle or an
  operand word leaves them untouched while the pulses say what happened.
  Assumes program memory presents the next word on fetch_word by the last
  quarter of each instruction cycle, and the datapath drives cond_true for
  skips and branches in that same quarter, from logic on clk_sys.
  Unconditional program counter changes report cond_true high as well.
  Two-word instructions take cond_true with their operand word instead.
*/
`include "mdt_regs.svh"

module mdt_decode_timing
  import mdt_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Fetch side
  input wire logic [15:0] fetch_word,
  input wire logic cond_true,
  // Cycle timing
  output logic [1:0] q_phase,
  output logic cycle_start,
  // Decoded controls
  output logic exec_valid,
  output mdt_pkg::mdt_class_e op_class,
  output logic [7:0] file_addr,
  output logic write_working_register,
  output logic write_file,
  output logic use_bank_select_register,
  output logic [2:0] bit_num,
  output logic [7:0] literal,
  output logic [1:0] indirect_pointer_register_sel,
  output logic fast_shadow,
  output logic [10:0] prog_addr,
  output mdt_pkg::mdt_tbl_e table_pointer_mode,
  output logic table_op,
  output logic [15:0] second_word,
  output logic second_valid,
  output logic insert_nop,
  output logic discard_fetch
);
  import mdt_pkg::*;

  // Whole state of the sequencer, registered in one place
  typedef struct packed {
    // Quarter counter, sequencer state and the word last dispatched
    logic [1:0] q;
    mdt_state_e st;
    logic [15:0] ir;
    // One-cycle markers of the instruction cycle
    logic cstart;
    logic ev;
    // Decoded fields, held until the next dispatch
    mdt_class_e cls;
    logic [7:0] fa;
    logic wwr;
    logic wf;
    logic ub;
    logic [2:0] bn;
    logic [7:0] lit;
    logic [1:0] ps;
    logic fs;
    logic [10:0] pa;
    mdt_tbl_e tm;
    logic to;
    // Operand word, pulses of the added cycle and the pending branch
    logic [15:0] w2;
    logic w2v;
    logic nop;
    logic disc;
    logic pend_br;
  } mdt_state_s;

  // Registered state and its next value
  mdt_state_s r;
  mdt_state_s next_r;
  // Raw outputs of the field decoder for the word on the fetch path
  mdt_class_e d_cls;
  mdt_tbl_e d_tm;
  logic d_two, d_br, d_skip, d_df, d_ub, d_fs, d_to;
  logic [7:0] d_fa, d_lit;
  logic [2:0] d_bn;
  logic [1:0] d_ps;
  logic [10:0] d_pa;

  ////////////////////////////////////////////////////////////////////////
  // Field decode of the word on the fetch path, sampled at the close of the fourth quarter
  mdt_field_decode u_dec
  (
    .word(fetch_word),
    .op_class(d_cls),
    .two_word(d_two),
    .is_branch(d_br),
    .is_skip(d_skip),
    .file_addr(d_fa),
    .dest_file(d_df),
    .use_bank(d_ub),
    .bit_num(d_bn),
    .literal(d_lit),
    .ptr_sel(d_ps),
    .fast_mode(d_fs),
    .prog_addr(d_pa),
    .tbl_mode(d_tm),
    .tbl_op(d_to)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state: quarter counter and per-cycle dispatch
  always_comb
  begin
    // Fields hold by default, pulses fall after one cycle
    next_r = r;
    next_r.cstart = 1'b0;
    next_r.ev = 1'b0;
    next_r.w2v = 1'b0;
    next_r.nop = 1'b0;
    next_r.disc = 1'b0;
    // Count quarters; the fourth closes the instruction cycle
    next_r.q = r.q + 2'h1; // RQ7
    if (r.q == 2'(`MDT_Q_PER_CYCLE - 3'h1))
    begin
      next_r.q = `MDT_Q_RESET;
      next_r.cstart = 1'b1;
      case (r.st)
        // First word: latch its fields and choose what the next cycle is
        MDT_ST_EXEC:
        begin
          next_r.ir = fetch_word;
          next_r.ev = 1'b1;
          next_r.cls = d_cls; // RQ1
          next_r.fa = d_fa; // RQ9
          next_r.wwr = (d_cls == MDT_CL_BYTE) && !d_df; // RQ10
          next_r.wf = (d_cls == MDT_CL_BYTE) && d_df; // RQ10
          next_r.ub = d_ub; // RQ14
          next_r.bn = d_bn; // RQ11
          next_r.lit = d_lit; // RQ12
          next_r.ps = d_ps; // RQ17
          next_r.fs = d_fs; // RQ15
          next_r.pa = d_pa; // RQ13
          next_r.tm = d_tm; // RQ16
          next_r.to = d_to; // RQ16
          next_r.pend_br = d_br;
          // A two-word first word always waits for its operand; a taken test
          // or branch on a one-word instruction adds one empty cycle
          if (d_two)
          begin
            next_r.st = MDT_ST_WORD2; // RQ18
          end
          else if ((d_skip && cond_true) || (d_br && cond_true))
          begin
            next_r.st = MDT_ST_FLUSH; // RQ5
          end
        end
        // Operand word: hand it over, never dispatch it as an instruction
        MDT_ST_WORD2:
        begin
          next_r.w2 = fetch_word; // RQ18
          next_r.w2v = 1'b1; // RQ6
          // A taken two-word branch adds a third, empty cycle
          next_r.st = (r.pend_br && cond_true) ? MDT_ST_FLUSH : MDT_ST_EXEC; // RQ8
        end
        // Added cycle: the word fetched in it is dropped, nothing dispatched
        MDT_ST_FLUSH:
        begin
          next_r.nop = 1'b1; // RQ5
          next_r.disc = 1'b1; // RQ19
          next_r.st = MDT_ST_EXEC;
        end
        // Unused code: fall back to dispatch
        default:
        begin
          next_r.st = MDT_ST_EXEC;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      // Fields and pulses clear; the held word reads as a no-op so that
      // nothing downstream mistakes the reset state for a dispatch
      r <= '0;
      r.ir <= `MDT_IR_RESET;
      r.cls <= MDT_CL_NOP;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign q_phase = r.q;
  assign cycle_start = r.cstart;
  assign exec_valid = r.ev;
  // Decoded fields, held between dispatches
  assign op_class = r.cls;
  assign file_addr = r.fa;
  assign write_working_register = r.wwr;
  assign write_file = r.wf;
  assign use_bank_select_register = r.ub;
  assign bit_num = r.bn;
  assign literal = r.lit;
  assign indirect_pointer_register_sel = r.ps;
  assign fast_shadow = r.fs;
  assign prog_addr = r.pa;
  assign table_pointer_mode = r.tm;
  assign table_op = r.to;
  // Operand word and the pulses of added cycles
  assign second_word = r.w2;
  assign second_valid = r.w2v;
  assign insert_nop = r.nop;
  assign discard_fetch = r.disc;
endmodule

// >>> verif/mdt_fetch_model.sv
/*
  Fetch path model: offers the queued word in the sampling quarter.
  Assumes q_phase comes from the decoder.
*/
module mdt_fetch_model
(
  // Phase and queued word
  input wire logic [1:0] q_phase,
  input wire logic [15:0] word_in,
  // Program word
  output logic [15:0] fetch_word
);
  // Bus is scrambled outside the sampling quarter
  assign fetch_word = (q_phase == 2'h3) ? word_in : ~word_in;
endmodule

// >>> verif/mdt_decode_timing_checker.sv
/*
  Port checker of the decode and timing block.
  Assumes it is bound to mdt_decode_timing.
*/
module mdt_decode_timing_checker
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Observed outputs
  input wire logic [1:0] q_phase,
  input wire logic cycle_start,
  input wire logic exec_valid,
  input wire mdt_pkg::mdt_class_e op_class,
  input wire logic [7:0] file_addr,
  input wire logic write_working_register,
  input wire logic write_file,
  input wire logic second_valid,
  input wire logic insert_nop,
  input wire logic discard_fetch
);
  import mdt_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Sequencing
  property p_cycle;
    cycle_start |-> q_phase == 2'h0 ##1 !cycle_start [*3] ##1 cycle_start;
  endproperty
  a_cycle: assert property (p_cycle) else $error("cycle length wrong");
  property p_exec;
    exec_valid |-> cycle_start && !insert_nop && !second_valid;
  endproperty
  a_exec: assert property (p_exec) else $error("operand word dispatched");
  property p_disc;
    insert_nop |-> discard_fetch && cycle_start && !exec_valid;
  endproperty
  a_disc: assert property (p_disc) else $error("added cycle not empty");
  property p_pair;
    second_valid |-> $past(exec_valid, 4);
  endproperty
  a_pair: assert property (p_pair) else $error("operand word out of place");
  property p_nop;
    insert_nop |-> $past(exec_valid, 4) || $past(second_valid, 4);
  endproperty
  a_nop: assert property (p_nop) else $error("added cycle without cause");
  // Destination and field holding
  property p_dest;
    exec_valid && op_class == MDT_CL_BYTE |-> write_file ^ write_working_register;
  endproperty
  a_dest: assert property (p_dest) else $error("byte destination wrong");
  property p_nobyte;
    op_class != MDT_CL_BYTE |-> !write_file && !write_working_register;
  endproperty
  a_nobyte: assert property (p_nobyte) else $error("stray destination");
  property p_hold;
    $changed(file_addr) |-> exec_valid;
  endproperty
  a_hold: assert property (p_hold) else $error("file field moved");
  c_exec: cover property (exec_valid);
  c_second: cover property (second_valid);
  c_nop: cover property (insert_nop);
endmodule
bind mdt_decode_timing mdt_decode_timing_checker mdt_decode_timing_checker_i (.clk_sys, .rst,
  .q_phase, .cycle_start, .exec_valid, .op_class, .file_addr, .write_working_register,
  .write_file, .second_valid, .insert_nop, .discard_fetch);

// >>> verif/test_mdt_decode_timing.sv
/*
  Self-checking bench of the decode and timing block.
  Assumes the fetch model and the bound checker are compiled.
*/
module test_mdt_decode_timing;
  timeunit 1ns;
  timeprecision 100ps;
  import mdt_pkg::*;
  ////////////////////////////////////////
  // Signals
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cond_true = 1'b0;
  logic [15:0] word_in = 16'h0000;
  logic [15:0] fetch_word, second_word;
  logic [1:0] q_phase, indirect_pointer_register_sel;
  logic [7:0] file_addr, literal;
  logic [2:0] bit_num;
  logic [10:0] prog_addr;
  mdt_class_e op_class;
  mdt_tbl_e table_pointer_mode;
  logic cycle_start, exec_valid, write_working_register, write_file, use_bank_select_register;
  logic fast_shadow, table_op, second_valid, insert_nop, discard_fetch;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  mdt_decode_timing mdt_decode_timing_i (.clk_sys, .rst, .fetch_word, .cond_true, .q_phase,
    .cycle_start, .exec_valid, .op_class, .file_addr, .write_working_register, .write_file,
    .use_bank_select_register, .bit_num, .literal, .indirect_pointer_register_sel,
    .fast_shadow, .prog_addr, .table_pointer_mode, .table_op, .second_word, .second_valid,
    .insert_nop, .discard_fetch);
  mdt_fetch_model mdt_fetch_model_i (.q_phase, .word_in, .fetch_word);
  // 200 MHz clock and run ceiling
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_total++;
      end_of_test();
    end
  end
  ////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Offer one word in the next sampling quarter, return in the answering cycle
  task automatic issue(input logic [15:0] w, input logic c);
    for (int n = 0; n < 4 && q_phase !== 2'h3; n++) @(posedge clk_sys) #1;
    word_in = w;
    cond_true = c;
    @(posedge clk_sys) #1;
    chk("cycle_start", 16'h1, cycle_start);
    chk("q_phase", 16'h0, q_phase);
  endtask
  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////
  // Scenarios
  task automatic t_byte();
    issue(16'h2612, 1'b0);
    chk("op_class", MDT_CL_BYTE, op_class);
    chk("file_addr", 16'h12, file_addr);
    chk("write_file", 16'h1, write_file);
    chk("bank", 16'h0, use_bank_select_register);
    issue(16'h2512, 1'b0);
    chk("working", 16'h1, write_working_register);
    chk("bank", 16'h1, use_bank_select_register);
  endtask
  task automatic t_bit_lit();
    issue(16'h9AFF, 1'b0);
    chk("op_class", MDT_CL_BIT, op_class);
    chk("bit_num", 16'h5, bit_num);
    chk("file_addr", 16'hFF, file_addr);
    issue(16'h0E55, 1'b0);
    chk("op_class", MDT_CL_LIT, op_class);
    chk("literal", 16'h55, literal);
    issue(16'hE800, 1'b0);
    chk("op_class", MDT_CL_EXT, op_class);
  endtask
  task automatic t_ctrl();
    for (int m = 0; m < 4; m++)
    begin
      issue({14'h0002, 2'(m)}, 1'b0);
      chk("table_op", 16'h1, table_op);
      chk("tbl_mode", 16'(m), table_pointer_mode);
    end
    for (int s = 0; s < 2; s++)
    begin
      issue({15'h0009, 1'(s)}, 1'b1);
      chk("op_class", MDT_CL_CTRL, op_class);
      chk("fast", 16'(s), fast_shadow);
      issue(16'h0E00, 1'b0);
      chk("insert_nop", 16'h1, insert_nop);
    end
  endtask
  task automatic t_skip();
    issue(16'hA234, 1'b1);
    issue(16'h0E11, 1'b0);
    chk("insert_nop", 16'h1, insert_nop);
    chk("discard", 16'h1, discard_fetch);
    chk("literal", 16'h34, literal);
    issue(16'hA234, 1'b0);
    issue(16'h0E11, 1'b0);
    chk("exec_valid", 16'h1, exec_valid);
    chk("literal", 16'h11, literal);
    issue(16'h6412, 1'b1);
    issue(16'h0E77, 1'b0);
    chk("insert_nop", 16'h1, insert_nop);
    chk("discard", 16'h1, discard_fetch);
    issue(16'hD005, 1'b1);
    issue(16'h0E66, 1'b0);
    chk("insert_nop", 16'h1, insert_nop);
    chk("op_class", MDT_CL_CTRL, op_class);
  endtask
  task automatic t_two();
    issue(16'hEE20, 1'b0);
    chk("ptr_sel", 16'h2, indirect_pointer_register_sel);
    issue(16'hF0AB, 1'b0);
    chk("second_valid", 16'h1, second_valid);
    chk("exec_valid", 16'h0, exec_valid);
    chk("second_word", 16'hF0AB, second_word);
    issue(16'h0E33, 1'b0);
    chk("insert_nop", 16'h0, insert_nop);
    issue(16'hEF05, 1'b0);
    chk("prog_addr", 16'h705, prog_addr);
    issue(16'hF123, 1'b1);
    issue(16'h0E44, 1'b0);
    chk("insert_nop", 16'h1, insert_nop);
    issue(16'hF456, 1'b0);
    chk("op_class", MDT_CL_NOP, op_class);
    issue(16'hC123, 1'b0);
    chk("op_class", MDT_CL_BYTE, op_class);
    chk("file_addr", 16'h23, file_addr);
    issue(16'hF789, 1'b0);
    chk("second_valid", 16'h1, second_valid);
    chk("second_word", 16'hF789, second_word);
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk_sys);
    #1 rst = 1'b0;
    chk("op_class", MDT_CL_NOP, op_class);
    t_byte();
    t_bit_lit();
    t_ctrl();
    t_skip();
    t_two();
    end_of_test();
  end
endmodule
